/* File: spm_consts.svh */
// Register map, field positions and reset values of the serial port
// Function
// - Standard mode: transmit-full sets on data write, clears on move to shifter
// - Deep mode: transmit-full sets when last slot filled, clears when one frees
// - Standard mode: receive-full sets on shifter copy, clears on data read
// - Deep mode: receive-full sets when last slot filled, clears when one frees
// - Master: clock-pin disable stops internal clock and releases clock pin
// - Data-out disable releases the serial output pin
// - Word-width bit selects 16-bit or 8-bit transfers of 16 or 8 pulses
// - Changing word width resets the port
// - Output from bit 7 or 15, input enters bit 0, MSB first
// - Master sample phase: end of bit when set, middle when clear
// - Edge bit picks output change edge, leading edge when framed; polarity bit picks idle level
// - Select enable makes non-framed slave honour active-low select pin
// - Master-enable set drives clock; clear follows external clock
// - Secondary divider: code 111 divides by 1 down to 000 by 8
// - Primary divider: codes 11,10,01,00 divide by 1,4,16,64; cascaded
// - Framed enable; sync direction makes select pin input or, in master mode, output
// - Sync polarity sets pulse level; sync edge sets pulse timing
// - Buffer enable selects DEPTH-deep buffers (4 or 8, default 8), else single holding registers
// - Master clock pulses only while data awaits transmission
// - Transfer end sets interrupt flag, stores word, sets receive-full
// - Completing a word while receive-full sets the overflow flag
// - Port enable activates port and takes the pins; clear disables
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPM_ADDR_STAT   3'h0
`define SPM_ADDR_CTL1   3'h1
`define SPM_ADDR_CTL2   3'h2
`define SPM_ADDR_DATA   3'h3
`define SPM_ADDR_FLAG   3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPM_ST_ENABLE   15
`define SPM_ST_IDLESTOP 13
`define SPM_ST_SREMPTY  7
`define SPM_ST_OVF      6
`define SPM_ST_RXEMPTY  5
`define SPM_ST_ISEL_LO  2
`define SPM_ST_TXFULL   1
`define SPM_ST_RXFULL   0
`define SPM_C1_CLKDIS   12
`define SPM_C1_DODIS    11
`define SPM_C1_WIDE     10
`define SPM_C1_SMPEND   9
`define SPM_C1_OUTEDGE  8
`define SPM_C1_SELEN    7
`define SPM_C1_IDLEPOL  6
`define SPM_C1_MASTER   5
`define SPM_C1_SEC_LO   2
`define SPM_C1_PRI_LO   0
`define SPM_C2_FRAMED   15
`define SPM_C2_SYNCDIR  14
`define SPM_C2_SYNCPOL  13
`define SPM_C2_SYNCEDGE 1
`define SPM_C2_DEEP     0

// ----------------------------------------------------------------
// Write masks and reset values
// ----------------------------------------------------------------
`define SPM_C1_MASK     16'h1FFF
`define SPM_C2_MASK     16'hE003
`define SPM_RST_WORD    16'h0000

`endif

/* File: spm_far_dev.sv */
// Far-end serial device answering a master port
`timescale 1ns/1ps

module spm_far_dev
(
    input  wire logic        sck,
    input  wire logic        pol,
    input  wire logic        wide,
    input  wire logic        clr,
    input  wire logic        sdo,
    input  wire logic [15:0] word,
    output logic             sdi,
    output logic      [15:0] got
);
    logic [15:0] tx = 16'h0000;
    logic        pa = 1'b0;
    logic        act;
    int          nf = 0;
    int          nr = 0;
    int          bits;

    assign act  = sck ^ pol;
    assign bits = wide ? 16 : 8;
    // Before the first bit the line shows the inverse of the held bit
    assign sdi  = (nr != 0) ? tx[bits-1] : ~tx[bits-1];

    always @(act, clr)
    begin
        if (!clr && act !== pa && act === 1'b1)
        begin
            tx = (nf % bits == 0) ? word : {tx[14:0], 1'b0};
            nr = nr + 1;
        end
        else if (!clr && act !== pa && act === 1'b0)
        begin
            got = {got[14:0], sdo};
            nf  = nf + 1;
        end
        if (clr)
        begin
            nf = 0;
            nr = 0;
        end
        pa = act;
    end
endmodule

/* File: spm_pkg.sv */
// Types shared by the serial port
package spm_pkg;

    typedef enum logic [1:0] {SPM_IDLE, SPM_PRE, SPM_SHIFT} spm_phase_e;

    typedef logic [15:0] spm_word_t;

endpackage

/* File: spm_port.sv */
// Serial port: register file, buffers, divider and shift engine
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "spm_consts.svh"

module spm_port
#(
    parameter int DEPTH = 8
)
(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic [2:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        SCK_I,
    output logic             SCK_O,
    output logic             SCK_OE,
    input  wire logic        SDI_I,
    output logic             SDO_O,
    output logic             SDO_OE,
    input  wire logic        SS_I,
    output logic             SS_O,
    output logic             SS_OE,
    output logic             IRQ_FLAG
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;

    generate
        if (DEPTH < 4 || DEPTH > 8 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("DEPTH must be 4 or 8");
        end
    endgenerate

    typedef struct packed
    {
        logic                          en;
        logic                          idlestop;
        logic [2:0]                    isel;
        logic                          ovf;
        logic                          irq;
        spm_pkg::spm_word_t            ctl1;
        spm_pkg::spm_word_t            ctl2;
        logic [DEPTH-1:0][15:0]        txq;
        logic [PW-1:0]                 tx_rd;
        logic [PW-1:0]                 tx_wr;
        logic [CW-1:0]                 tx_cnt;
        logic [DEPTH-1:0][15:0]        rxq;
        logic [PW-1:0]                 rx_rd;
        logic [PW-1:0]                 rx_wr;
        logic [CW-1:0]                 rx_cnt;
        spm_pkg::spm_phase_e           st;
        spm_pkg::spm_word_t            sr;
        spm_pkg::spm_word_t            cur;
        logic                          held;
        logic                          half;
        logic [4:0]                    bits;
        logic [9:0]                    div;
        logic                          sck_q;
        logic                          sck_o;
        logic                          sck_oe;
        logic                          sdo;
        logic                          sdo_oe;
        logic                          ss_o;
        logic                          ss_oe;
        spm_pkg::spm_word_t            rdata;
    } spm_regs_s;

    spm_regs_s          r_ff;
    spm_regs_s          nxt_r;
    logic               mst;
    logic               ext;
    logic               wide;
    logic               frm;
    logic               oedge;
    logic               clock_idle_polarity;
    logic [CW-1:0]      cap;
    logic               tick;
    logic               lead;
    logic               trail;
    logic               chg_e;
    logic               smp_e;
    logic               sel_ok;
    logic               abort;
    logic               load;
    logic               complete;
    logic               tx_push;
    logic               tx_pop;
    logic               rx_push;
    logic               rx_pop;
    logic               wide_chg;
    logic               sync_act;
    spm_pkg::spm_word_t sh;
    spm_pkg::spm_word_t ld_word;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [9:0] half_limit(input logic [15:0] c1);
        logic [9:0] pri;
        logic [9:0] sec;
        pri = 10'h001 << {~c1[`SPM_C1_PRI_LO+:2], 1'b0};
        sec = 10'h008 - {7'h00, c1[`SPM_C1_SEC_LO+:3]};
        return 10'(pri * sec) - 10'h001;
    endfunction

    function automatic logic top_bit(input logic [15:0] w,
                                     input logic        wd);
        return wd ? w[15] : w[7];
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_r    = r_ff;
        mst      = r_ff.ctl1[`SPM_C1_MASTER];
        ext      = !mst || r_ff.ctl1[`SPM_C1_CLKDIS];
        wide     = r_ff.ctl1[`SPM_C1_WIDE];
        frm      = r_ff.ctl2[`SPM_C2_FRAMED];
        oedge    = r_ff.ctl1[`SPM_C1_OUTEDGE] && !frm;
        clock_idle_polarity      = r_ff.ctl1[`SPM_C1_IDLEPOL];
        cap      = r_ff.ctl2[`SPM_C2_DEEP] ? CW'(DEPTH) : CW'(1);
        tick     = (r_ff.div == half_limit(r_ff.ctl1));
        lead     = (SCK_I != clock_idle_polarity) && (r_ff.sck_q == clock_idle_polarity);
        trail    = (SCK_I == clock_idle_polarity) && (r_ff.sck_q != clock_idle_polarity);
        chg_e    = oedge ? trail : lead;
        smp_e    = oedge ? lead : trail;
        abort    = !mst && !frm && r_ff.ctl1[`SPM_C1_SELEN] && SS_I;
        if (mst)
            sel_ok = 1'b1;
        else if (frm)
            sel_ok = r_ff.half ||
                     (SS_I == r_ff.ctl2[`SPM_C2_SYNCPOL]);
        else
            sel_ok = !r_ff.ctl1[`SPM_C1_SELEN] || !SS_I;
        load     = 1'b0;
        complete = 1'b0;
        tx_push  = 1'b0;
        tx_pop   = 1'b0;
        rx_push  = 1'b0;
        rx_pop   = 1'b0;
        wide_chg = 1'b0;
        sh       = r_ff.sr;
        ld_word  = r_ff.txq[r_ff.tx_rd];
        nxt_r.sck_q = SCK_I;
        nxt_r.rdata = `SPM_RST_WORD;

        // Register writes
        if (WR)
        begin
            case (ADDR)
                `SPM_ADDR_STAT:
                begin
                    nxt_r.en       = WDATA[`SPM_ST_ENABLE];
                    nxt_r.idlestop = WDATA[`SPM_ST_IDLESTOP];
                    nxt_r.isel     = WDATA[`SPM_ST_ISEL_LO+:3];
                    if (!WDATA[`SPM_ST_OVF])
                        nxt_r.ovf = 1'b0;
                end
                `SPM_ADDR_CTL1:
                    if (!r_ff.en)
                    begin
                        nxt_r.ctl1 = WDATA & `SPM_C1_MASK;
                        wide_chg   = WDATA[`SPM_C1_WIDE] != wide;
                    end
                `SPM_ADDR_CTL2:
                    if (!r_ff.en)
                        nxt_r.ctl2 = WDATA & `SPM_C2_MASK;
                `SPM_ADDR_DATA:
                    tx_push = (r_ff.tx_cnt < cap);
                `SPM_ADDR_FLAG:
                    if (WDATA[0])
                        nxt_r.irq = 1'b0;
                default:
                    ;
            endcase
        end

        // Register reads, one cycle later
        if (RD)
        begin
            case (ADDR)
                `SPM_ADDR_STAT:
                    nxt_r.rdata = {r_ff.en, 1'b0, r_ff.idlestop, 2'b00,
                                   mst ? 3'(r_ff.tx_cnt) : 3'(r_ff.rx_cnt),
                                   !r_ff.held, r_ff.ovf,
                                   r_ff.rx_cnt == '0, r_ff.isel,
                                   r_ff.tx_cnt == cap,
                                   r_ff.rx_cnt == cap};
                `SPM_ADDR_CTL1:
                    nxt_r.rdata = r_ff.ctl1;
                `SPM_ADDR_CTL2:
                    nxt_r.rdata = r_ff.ctl2;
                `SPM_ADDR_DATA:
                begin
                    nxt_r.rdata = r_ff.rxq[r_ff.rx_rd];
                    rx_pop      = (r_ff.rx_cnt != '0);
                end
                `SPM_ADDR_FLAG:
                    nxt_r.rdata = {15'h0000, r_ff.irq};
                default:
                    ;
            endcase
        end

        // ----------------------------------------------------------------
        // Shift engine
        // ----------------------------------------------------------------
        unique case (r_ff.st)
            spm_pkg::SPM_IDLE:
            begin
                nxt_r.half = 1'b0;
                nxt_r.bits = 5'h00;
                nxt_r.div  = 10'h000;
                if (r_ff.en && ext)
                    nxt_r.st = spm_pkg::SPM_SHIFT;
                else if (r_ff.en && r_ff.tx_cnt != '0)
                begin
                    load = 1'b1;
                    if (frm && !r_ff.ctl2[`SPM_C2_SYNCEDGE])
                        nxt_r.st = spm_pkg::SPM_PRE;
                    else
                        nxt_r.st = spm_pkg::SPM_SHIFT;
                end
            end
            spm_pkg::SPM_PRE:
            begin
                nxt_r.div = tick ? 10'h000 : r_ff.div + 10'h001;
                if (tick)
                begin
                    nxt_r.half = !r_ff.half;
                    if (r_ff.half)
                        nxt_r.st = spm_pkg::SPM_SHIFT;
                end
            end
            spm_pkg::SPM_SHIFT:
            begin
                if (!ext)
                begin
                    nxt_r.div = tick ? 10'h000 : r_ff.div + 10'h001;
                    if (tick)
                    begin
                        nxt_r.half = !r_ff.half;
                        if (r_ff.half == r_ff.ctl1[`SPM_C1_SMPEND])
                            sh = {r_ff.sr[14:0], SDI_I};
                        nxt_r.sr = sh;
                        if (r_ff.half)
                        begin
                            nxt_r.bits = r_ff.bits + 5'h01;
                            if (r_ff.bits == (wide ? 5'h0F : 5'h07))
                                complete = 1'b1;
                            else
                                nxt_r.sdo = top_bit(sh, wide);
                        end
                    end
                end
                else if (abort)
                begin
                    nxt_r.sr   = r_ff.cur;
                    nxt_r.bits = 5'h00;
                    nxt_r.half = 1'b0;
                    nxt_r.sdo  = top_bit(r_ff.cur, wide);
                end
                else if (sel_ok && smp_e)
                begin
                    sh          = {r_ff.sr[14:0], SDI_I};
                    nxt_r.sr    = sh;
                    nxt_r.half  = 1'b1;
                    nxt_r.bits  = r_ff.bits + 5'h01;
                    if (r_ff.bits == (wide ? 5'h0F : 5'h07))
                        complete = 1'b1;
                end
                else if (sel_ok && chg_e)
                begin
                    nxt_r.sdo  = top_bit(r_ff.sr, wide);
                    nxt_r.half = 1'b1;
                end
                else if (!r_ff.held && !r_ff.half && r_ff.tx_cnt != '0)
                    load = 1'b1;
            end
            default:
                nxt_r.st = spm_pkg::SPM_IDLE;
        endcase

        if (load)
        begin
            tx_pop     = 1'b1;
            nxt_r.sr   = ld_word;
            nxt_r.cur  = ld_word;
            nxt_r.sdo  = top_bit(ld_word, wide);
            nxt_r.held = 1'b1;
        end

        // Transfer end; hardware sets win over software clears
        if (complete)
        begin
            nxt_r.irq  = 1'b1;
            nxt_r.st   = spm_pkg::SPM_IDLE;
            nxt_r.held = 1'b0;
            nxt_r.half = 1'b0;
            if (r_ff.rx_cnt == cap)
                nxt_r.ovf = 1'b1;
            else
                rx_push = 1'b1;
        end

        // ----------------------------------------------------------------
        // Buffer pointers
        // ----------------------------------------------------------------
        if (tx_push)
        begin
            nxt_r.txq[r_ff.tx_wr] = WDATA;
            nxt_r.tx_wr           = r_ff.tx_wr + 1'b1;
        end
        if (tx_pop)
            nxt_r.tx_rd = r_ff.tx_rd + 1'b1;
        nxt_r.tx_cnt = r_ff.tx_cnt + {{PW{1'b0}}, tx_push}
                                   - {{PW{1'b0}}, tx_pop};
        if (rx_push)
        begin
            nxt_r.rxq[r_ff.rx_wr] = wide ? sh : {8'h00, sh[7:0]};
            nxt_r.rx_wr           = r_ff.rx_wr + 1'b1;
        end
        if (rx_pop)
            nxt_r.rx_rd = r_ff.rx_rd + 1'b1;
        nxt_r.rx_cnt = r_ff.rx_cnt + {{PW{1'b0}}, rx_push}
                                   - {{PW{1'b0}}, rx_pop};

        // Disable or width change stops the engine
        if (!nxt_r.en || wide_chg)
        begin
            nxt_r.st   = spm_pkg::SPM_IDLE;
            nxt_r.held = 1'b0;
            nxt_r.half = 1'b0;
            nxt_r.bits = 5'h00;
            nxt_r.div  = 10'h000;
        end
        if (wide_chg)
        begin
            nxt_r.tx_rd  = '0;
            nxt_r.tx_wr  = '0;
            nxt_r.tx_cnt = '0;
            nxt_r.rx_rd  = '0;
            nxt_r.rx_wr  = '0;
            nxt_r.rx_cnt = '0;
            nxt_r.ovf    = 1'b0;
        end

        // ----------------------------------------------------------------
        // Pin drive
        // ----------------------------------------------------------------
        nxt_r.sck_oe = nxt_r.en && nxt_r.ctl1[`SPM_C1_MASTER]
                       && !nxt_r.ctl1[`SPM_C1_CLKDIS];
        nxt_r.sck_o  = nxt_r.ctl1[`SPM_C1_IDLEPOL] ^
                       ((nxt_r.st == spm_pkg::SPM_SHIFT) &&
                        (nxt_r.half ^ !oedge));
        nxt_r.sdo_oe = nxt_r.en && !nxt_r.ctl1[`SPM_C1_DODIS] &&
                       !(!nxt_r.ctl1[`SPM_C1_MASTER] && !frm &&
                         nxt_r.ctl1[`SPM_C1_SELEN] && SS_I);
        sync_act     = (nxt_r.st == spm_pkg::SPM_PRE) ||
                       (nxt_r.ctl2[`SPM_C2_SYNCEDGE] &&
                        nxt_r.st == spm_pkg::SPM_SHIFT &&
                        nxt_r.bits == 5'h00);
        nxt_r.ss_oe  = nxt_r.en && nxt_r.ctl2[`SPM_C2_FRAMED] &&
                       !nxt_r.ctl2[`SPM_C2_SYNCDIR] &&
                       nxt_r.ctl1[`SPM_C1_MASTER];
        nxt_r.ss_o   = nxt_r.ctl2[`SPM_C2_SYNCPOL] ^ !sync_act;
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign RDATA    = r_ff.rdata;
    assign SCK_O    = r_ff.sck_o;
    assign SCK_OE   = r_ff.sck_oe;
    assign SDO_O    = r_ff.sdo;
    assign SDO_OE   = r_ff.sdo_oe;
    assign SS_O     = r_ff.ss_o;
    assign SS_OE    = r_ff.ss_oe;
    assign IRQ_FLAG = r_ff.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    tx_full_rise_a: assert property (
        $rose(r_ff.tx_cnt == cap) |-> $past(WR && ADDR == `SPM_ADDR_DATA))
        else $error("transmit-full rose without a data write");
    rx_full_fall_a: assert property (
        $fell(r_ff.rx_cnt == cap) && !$past(wide_chg)
        |-> $past(RD && ADDR == `SPM_ADDR_DATA))
        else $error("receive-full fell without a data read");
    overflow_set_a: assert property (
        complete && r_ff.rx_cnt == cap |=> r_ff.ovf)
        else $error("overflow not flagged");
    done_flag_a: assert property (
        complete |=> IRQ_FLAG && r_ff.st == spm_pkg::SPM_IDLE)
        else $error("transfer end did not raise the flag");
    word_bits_a: assert property (
        r_ff.st == spm_pkg::SPM_SHIFT
        |-> r_ff.bits <= (wide ? 5'h0F : 5'h07))
        else $error("transfer length wrong");
    dout_release_a: assert property (
        r_ff.en && r_ff.ctl1[`SPM_C1_DODIS] ##1 $stable(r_ff.ctl1)
        |-> !SDO_OE)
        else $error("data out driven while disabled");
    clk_release_a: assert property (
        r_ff.ctl1[`SPM_C1_CLKDIS] |-> !SCK_OE)
        else $error("clock pin driven while disabled");
    clk_idle_a: assert property (
        r_ff.st == spm_pkg::SPM_IDLE |-> SCK_O == clock_idle_polarity)
        else $error("clock left idle level without data");
    width_reset_a: assert property (
        wide_chg |=> r_ff.tx_cnt == '0 && r_ff.rx_cnt == '0)
        else $error("width change did not reset the port");

endmodule

/* File: spm_port_tb_top.sv */
// Register-level bench for the serial port
`timescale 1ns/1ps

module spm_port_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  adr = 3'h0;
    logic [15:0] wd = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdat;
    logic        sck;
    logic        sck_oe;
    logic        sdi;
    logic        sdo;
    logic        sdo_oe;
    logic        irq;
    logic        pol = 1'b0;
    logic        wide = 1'b0;
    logic        clr = 1'b1;
    logic [15:0] got;
    logic [15:0] m;
    logic        s_sck = 1'b0;
    logic        s_sdi = 1'b0;
    logic        s_ss_n = 1'b1;
    logic        slv = 1'b0;
    logic [7:0]  rcv;
    logic [7:0]  sin = 8'hC6;
    logic [15:0] cfg [4] = '{16'h043F, 16'h007A, 16'h0221, 16'h002C};
    int          hv [4] = '{1, 8, 128, 320};
    int          miscompares = 0;
    int          checked = 0;
    int          n;

    always #2.5 clk = ~clk;

    spm_port uut
    (
        .REF_CLK(clk), .RST(rst), .ADDR(adr), .WDATA(wd), .WR(wr),
        .RD(rd), .RDATA(rdat), .SCK_I(s_sck), .SCK_O(sck),
        .SCK_OE(sck_oe), .SDI_I(slv ? s_sdi : sdi), .SDO_O(sdo),
        .SDO_OE(sdo_oe), .SS_I(s_ss_n), .SS_O(), .SS_OE(), .IRQ_FLAG(irq)
    );

    spm_far_dev dev
    (
        .sck(sck), .pol(pol), .wide(wide), .clr(clr), .sdo(sdo),
        .word(16'hA5C3), .sdi(sdi), .got(got)
    );

    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        checked++;
        if (a !== e)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, a, e);
        end
    endtask

    task automatic wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        adr <= a;
        wd  <= d;
        wr  <= 1'b1;
        @(posedge clk);
        wr  <= 1'b0;
    endtask

    task automatic rreg(input logic [2:0] a, input logic [15:0] k,
                        input logic [15:0] e);
        @(posedge clk);
        adr <= a;
        rd  <= 1'b1;
        @(posedge clk);
        rd  <= 1'b0;
        #1;
        chk(rdat & k, e);
    endtask

    task automatic wait_irq(input int lim);
        n = 0;
        @(posedge clk);
        while (irq !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= lim)
        begin
            miscompares++;
            $display("unexpected at %0t: no completion", $time);
            end_sim();
        end
    endtask

    task automatic wait_sck(input logic lv);
        n = 0;
        while (sck === lv && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000)
        begin
            miscompares++;
            $display("unexpected at %0t: serial clock stuck", $time);
            end_sim();
        end
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rreg(3'h0, 16'hFFFF, 16'h00A0);
        rreg(3'h1, 16'hFFFF, 16'h0000);
        rreg(3'h2, 16'hFFFF, 16'h0000);
        rreg(3'h7, 16'hFFFF, 16'h0000);
        wreg(3'h1, 16'hFFFF);
        wreg(3'h2, 16'hFFFF);
        rreg(3'h1, 16'hFFFF, 16'h1FFF);
        rreg(3'h2, 16'hFFFF, 16'hE003);
        wreg(3'h2, 16'h0000);
        wreg(3'h0, 16'h8000);
        repeat (2) @(posedge clk);
        chk({14'h0, sck_oe, sdo_oe}, 16'h0000);
        wreg(3'h0, 16'h0000);
        $display("test registers done");
        foreach (cfg[i])
        begin
            clr  <= 1'b1;
            pol  <= cfg[i][6];
            wide <= cfg[i][10];
            m = cfg[i][10] ? 16'hFFFF : 16'h00FF;
            wreg(3'h1, cfg[i]);
            wreg(3'h0, 16'h8000);
            wreg(3'h1, ~cfg[i]);
            rreg(3'h1, 16'hFFFF, cfg[i]);
            chk({14'h0, sck_oe, sdo_oe}, 16'h0003);
            chk({15'h0, sck}, {15'h0, pol});
            clr <= 1'b0;
            wreg(3'h3, 16'hA5C3);
            wait_sck(pol);
            wait_sck(~pol);
            chk(16'(n), 16'(hv[i]));
            wait_irq(40 * hv[i] + 50);
            rreg(3'h0, 16'h0001, 16'h0001);
            rreg(3'h3, 16'hFFFF, 16'hA5C3 & m);
            rreg(3'h0, 16'h0001, 16'h0000);
            chk(got & m, 16'hA5C3 & m);
            wreg(3'h4, 16'h0001);
            rreg(3'h4, 16'h0001, 16'h0000);
            wreg(3'h0, 16'h0000);
            $display("test transfer %0d done", i);
        end
        clr  <= 1'b1;
        pol  <= 1'b0;
        wide <= 1'b0;
        wreg(3'h1, 16'h003F);
        wreg(3'h0, 16'h8000);
        clr <= 1'b0;
        wreg(3'h3, 16'h0011);
        wreg(3'h3, 16'h0022);
        rreg(3'h0, 16'h0002, 16'h0002);
        wait_irq(100);
        rreg(3'h0, 16'h0002, 16'h0000);
        wreg(3'h4, 16'h0001);
        wait_irq(100);
        rreg(3'h0, 16'h0041, 16'h0041);
        wreg(3'h0, 16'h8000);
        rreg(3'h3, 16'h0000, 16'h0000);
        rreg(3'h0, 16'h0041, 16'h0000);
        wreg(3'h0, 16'h0000);
        $display("test overflow done");
        clr <= 1'b1;
        wreg(3'h1, 16'h003D);
        wreg(3'h2, 16'h0001);
        wreg(3'h0, 16'h8000);
        wreg(3'h4, 16'h0001);
        clr <= 1'b0;
        repeat (8) wreg(3'h3, 16'h0055);
        rreg(3'h0, 16'h0002, 16'h0000);
        wreg(3'h3, 16'h0066);
        rreg(3'h0, 16'h0002, 16'h0002);
        wait_irq(700);
        rreg(3'h0, 16'h0002, 16'h0000);
        repeat (8)
        begin
            wreg(3'h4, 16'h0001);
            wait_irq(700);
        end
        rreg(3'h0, 16'h0041, 16'h0041);
        rreg(3'h3, 16'h0000, 16'h0000);
        rreg(3'h0, 16'h0001, 16'h0000);
        $display("test deep buffer done");
        clr <= 1'b1;
        wreg(3'h0, 16'h0000);
        wreg(3'h2, 16'h0000);
        wreg(3'h1, 16'h0480);
        wreg(3'h1, 16'h0080);
        wreg(3'h4, 16'h0001);
        wreg(3'h0, 16'h8000);
        slv <= 1'b1;
        rreg(3'h0, 16'h0021, 16'h0020);
        chk({15'h0, sdo_oe}, 16'h0000);
        @(posedge clk);
        s_ss_n <= 1'b0;
        wreg(3'h3, 16'h005A);
        chk({15'h0, sdo_oe}, 16'h0001);
        for (int b = 7; b >= 0; b--)
        begin
            repeat (3) @(posedge clk);
            s_sck <= 1'b1;
            s_sdi <= sin[b];
            repeat (3) @(posedge clk);
            rcv[b] = sdo;
            s_sck <= 1'b0;
        end
        wait_irq(20);
        chk({8'h00, rcv}, 16'h005A);
        rreg(3'h3, 16'hFFFF, 16'h00C6);
        @(posedge clk);
        s_ss_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({15'h0, sdo_oe}, 16'h0000);
        $display("test slave done");
        end_sim();
    end
endmodule
